// ==== core/scp_pkg.sv ====
package scp_pkg;
    // I/O addresses of the ports this block decodes
    localparam logic [15:0] PORT_B_ADDR = 16'h0061;
    localparam logic [15:0] PORT_A_ADDR = 16'h0092;
    localparam logic [15:0] CRAM_INDEX_ADDR = 16'h0070;
    localparam logic [15:0] ARB_ADDR = 16'h0090;
    // Port B field positions
    localparam int PB_IRQ_CLR = 7;
    localparam int PB_PAR_FLAG = 7;
    localparam int PB_CHK_FLAG = 6;
    localparam int PB_T2_OUT = 5;
    localparam int PB_REFRESH = 4;
    localparam int PB_CHK_EN_N = 3;
    localparam int PB_PAR_EN_N = 2;
    localparam int PB_SPK_EN = 1;
    localparam int PB_T2_GATE = 0;
    // Port A field positions
    localparam int PA_WDOG = 4;
    localparam int PA_LOCK = 3;
    localparam int PA_GATE20 = 1;
    localparam int PA_HOT_RST = 0;
    // Other field positions
    localparam int CRAM_NMI_MASK = 7;
    localparam int ARB_NMI_HOLD = 6;
    // Values after power-on reset
    localparam logic NMI_MASK_RST = 1'b1;
    localparam logic CHK_EN_N_RST = 1'b1;
    localparam logic PAR_EN_N_RST = 1'b1;
    // Alternate reset timing, times in ns
    localparam int CLK_NS = 10;
    localparam int ALT_DELAY_NS = 6720;
    localparam int ALT_PULSE_NS = 100;
    localparam int ALT_TOTAL_NS = 13400;
    localparam int ALT_DELAY_CYC = (ALT_DELAY_NS + CLK_NS - 1) / CLK_NS;
    localparam int ALT_PULSE_CYC = (ALT_PULSE_NS + CLK_NS - 1) / CLK_NS;
    localparam int ALT_TOTAL_CYC = ALT_TOTAL_NS / CLK_NS;
    localparam int ALT_CNT_W = 11;
endpackage : scp_pkg

// ==== core/scp_alt_if.sv ====
`timescale 1ns/1ps
// Handshake between the port logic and the alternate reset sequencer
interface scp_alt_if;
    logic start;
    logic pulse;
    logic busy;
    modport ctl (output start, input pulse, input busy);
    modport seq (input start, output pulse, output busy);
endinterface : scp_alt_if

// ==== core/scp_alt_seq.sv ====
`timescale 1ns/1ps
module scp_alt_seq (
    input wire logic clk_i, // System clock
    input wire logic rst_i, // System reset
    scp_alt_if.seq alt // Start, pulse and busy
);
    import scp_pkg::*;

    typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_PULSE, ST_TAIL} scp_seq_e;

    scp_seq_e state_r;
    scp_seq_e state_nxt;
    logic [ALT_CNT_W-1:0] cnt_r;
    logic [ALT_CNT_W-1:0] cnt_nxt;
    logic pulse_r;
    logic busy_r;

    localparam logic [ALT_CNT_W-1:0] DLY_END = ALT_CNT_W'(ALT_DELAY_CYC - 1);
    localparam logic [ALT_CNT_W-1:0] PLS_END =
        ALT_CNT_W'(ALT_DELAY_CYC + ALT_PULSE_CYC - 1);
    localparam logic [ALT_CNT_W-1:0] TOT_END = ALT_CNT_W'(ALT_TOTAL_CYC - 1);

    // Delay, pulse, then hold busy until the whole operation has elapsed
    always_comb begin
        state_nxt = state_r;
        cnt_nxt = cnt_r + ALT_CNT_W'(1);
        case (state_r)
            ST_IDLE: begin
                cnt_nxt = '0;
                if (alt.start) begin
                    state_nxt = ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (cnt_r == DLY_END) begin
                    state_nxt = ST_PULSE;
                end
            end
            ST_PULSE: begin
                if (cnt_r == PLS_END) begin
                    state_nxt = ST_TAIL;
                end
            end
            ST_TAIL: begin
                if (cnt_r == TOT_END) begin
                    state_nxt = ST_IDLE;
                end
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_r <= ST_IDLE;
            cnt_r <= '0;
            pulse_r <= 1'b0;
            busy_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            pulse_r <= (state_nxt == ST_PULSE);
            busy_r <= (state_nxt != ST_IDLE);
        end
    end

    assign alt.pulse = pulse_r;
    assign alt.busy = busy_r;
endmodule : scp_alt_seq

// ==== core/scp_ports.sv ====
`timescale 1ns/1ps
// Functional notes
// - NMI from parity, check, time-out, watchdog
// - Pending NMI halts arbitration until cleared
// - Mask gates only parity and channel check
// - Power-on sets NMI mask to one
// - System reset clears pending NMI state
// - Port B bit 7 write clears timer latch
// - Port B bits 7,6 report check flags
// - Port B bit 5 reads timer 2 output
// - Port B bit 4 toggles per refresh
// - Bit 3 channel-check enable, low, power-on one
// - Bit 2 parity-check enable, low, power-on one
// - Bits 1,0 speaker enable and timer gate
// - Port A bit 4 reads watchdog time-out
// - Port A bit 3 lock, cleared by power-off
// - Port A bit 1 gates address line twenty
// - Bit 0 rise pulses alternate reset briefly
// - Reset after 6.72 us, whole 13.4 us
// - Bit 0 stays set through alternate reset
// - Password bytes blocked after self test
module scp_ports (
    input wire logic SYS_CLK_I, // System clock, 100 MHz
    input wire logic RST_I, // System reset, sync, high
    input wire logic POR_I, // Power-on reset, sync, high
    input wire logic [15:0] IO_ADDR_I, // I/O address
    input wire logic IO_WR_I, // I/O write strobe
    input wire logic IO_RD_I, // I/O read strobe
    input wire logic [7:0] IO_WDATA_I, // I/O write data
    output logic [7:0] IO_RDATA_O, // I/O read data, next cycle
    input wire logic PARITY_ERR_I, // Memory parity error
    input wire logic CHAN_CHECK_I, // Channel check
    input wire logic CHAN_TIMEOUT_I, // Channel time-out
    input wire logic WATCHDOG_TO_I, // Watchdog time-out
    input wire logic TIMER0_OUT_I, // Timer 0 output
    input wire logic TIMER2_OUT_I, // Timer 2 output
    input wire logic REFRESH_REQ_I, // Refresh request pulse
    output logic NMI_O, // Nonmaskable interrupt
    output logic ARB_HALT_O, // Bus arbitration halted
    output logic TIMER_ZERO_IRQ_O, // Interrupt line 0 latch
    output logic SPEAKER_DATA_EN_O, // Speaker data enable
    output logic TIMER2_GATE_O, // Timer 2 gate
    output logic ADDRESS_LINE_TWENTY_GATE_O, // Line 20 enable
    output logic PASSWORD_BLOCK_O, // Password bytes blocked
    output logic CPU_ALT_RESET_O // Alternate processor reset
);
    import scp_pkg::*;

    scp_alt_if alt ();

    // Control state
    logic nmi_mask_r;
    logic nmi_r;
    logic par_flag_r;
    logic chk_flag_r;
    logic wdog_flag_r;
    logic tmr_irq_r;
    logic t0_prev_r;
    logic refresh_r;
    logic chk_en_n_r;
    logic par_en_n_r;
    logic spk_en_r;
    logic t2_gate_r;
    logic lock_r;
    logic gate20_r;
    logic hot_rst_r;
    logic alt_start_r;
    logic alt_rst_r;
    logic [7:0] rdata_r;
    logic [7:0] rdata_nxt;

    // Address decode and strobes
    wire sel_b = (IO_ADDR_I == PORT_B_ADDR);
    wire sel_a = (IO_ADDR_I == PORT_A_ADDR);
    wire wr_b = IO_WR_I && sel_b;
    wire wr_a = IO_WR_I && sel_a;
    wire wr_idx = IO_WR_I && (IO_ADDR_I == CRAM_INDEX_ADDR);
    wire wr_arb = IO_WR_I && (IO_ADDR_I == ARB_ADDR);

    // Event sources; flags only latch while their enable is low
    wire par_evt = PARITY_ERR_I && !par_en_n_r;
    wire chk_evt = CHAN_CHECK_I && !chk_en_n_r;
    wire masked_src = (par_evt || chk_evt) && !nmi_mask_r;
    wire nmi_src = masked_src || CHAN_TIMEOUT_I
        || WATCHDOG_TO_I;
    wire arb_resume = wr_arb && !IO_WDATA_I[ARB_NMI_HOLD];
    wire t0_rise = TIMER0_OUT_I && !t0_prev_r;
    wire tmr_irq_clr = wr_b && IO_WDATA_I[PB_IRQ_CLR];
    wire hot_rise = wr_a && IO_WDATA_I[PA_HOT_RST]
        && !hot_rst_r;

    // Read views; reserved port A bits read as zero
    wire [7:0] port_b_view = {par_flag_r, chk_flag_r, TIMER2_OUT_I,
        refresh_r, chk_en_n_r, par_en_n_r, spk_en_r, t2_gate_r};
    wire [7:0] port_a_view = {3'h0, wdog_flag_r, lock_r, 1'b0,
        gate20_r, hot_rst_r};

    // Registered read data; unmapped reads return zero
    always_comb begin
        rdata_nxt = 8'h00;
        if (IO_RD_I && sel_b) begin
            rdata_nxt = port_b_view;
        end else if (IO_RD_I && sel_a) begin
            rdata_nxt = port_a_view;
        end
    end

    // NMI mask lives in the clock RAM index register
    always_ff @(posedge SYS_CLK_I) begin
        if (POR_I) begin
            nmi_mask_r <= NMI_MASK_RST;
        end else if (wr_idx) begin
            nmi_mask_r <= IO_WDATA_I[CRAM_NMI_MASK];
        end
    end

    // Pending NMI; a new source beats a resume in the same cycle
    always_ff @(posedge SYS_CLK_I) begin
        if (RST_I || POR_I) begin
            nmi_r <= 1'b0;
        end else if (nmi_src) begin
            nmi_r <= 1'b1;
        end else if (arb_resume) begin
            nmi_r <= 1'b0;
        end
    end

    // Check flags clear while their enable is held off
    always_ff @(posedge SYS_CLK_I) begin
        if (RST_I || POR_I) begin
            par_flag_r <= 1'b0;
            chk_flag_r <= 1'b0;
        end else begin
            par_flag_r <= par_evt || (par_flag_r && !par_en_n_r);
            chk_flag_r <= chk_evt || (chk_flag_r && !chk_en_n_r);
        end
    end

    // Watchdog status is sticky until a reset
    always_ff @(posedge SYS_CLK_I) begin
        if (RST_I || POR_I) begin
            wdog_flag_r <= 1'b0;
        end else if (WATCHDOG_TO_I) begin
            wdog_flag_r <= 1'b1;
        end
    end

    // Timer 0 latch; a rising edge wins over a clear
    always_ff @(posedge SYS_CLK_I) begin
        if (RST_I || POR_I) begin
            tmr_irq_r <= 1'b0;
            t0_prev_r <= 1'b0;
        end else begin
            t0_prev_r <= TIMER0_OUT_I;
            tmr_irq_r <= t0_rise || (tmr_irq_r && !tmr_irq_clr);
        end
    end

    // Refresh toggle flag
    always_ff @(posedge SYS_CLK_I) begin
        if (RST_I || POR_I) begin
            refresh_r <= 1'b0;
        end else if (REFRESH_REQ_I) begin
            refresh_r <= !refresh_r;
        end
    end

    // Check enables are forced off only at power-on
    always_ff @(posedge SYS_CLK_I) begin
        if (POR_I) begin
            chk_en_n_r <= CHK_EN_N_RST;
            par_en_n_r <= PAR_EN_N_RST;
        end else if (wr_b) begin
            chk_en_n_r <= IO_WDATA_I[PB_CHK_EN_N];
            par_en_n_r <= IO_WDATA_I[PB_PAR_EN_N];
        end
    end

    // Speaker controls; bits 6 to 4 are not stored
    always_ff @(posedge SYS_CLK_I) begin
        if (RST_I || POR_I) begin
            spk_en_r <= 1'b0;
            t2_gate_r <= 1'b0;
        end else if (wr_b) begin
            spk_en_r <= IO_WDATA_I[PB_SPK_EN];
            t2_gate_r <= IO_WDATA_I[PB_T2_GATE];
        end
    end

    // Security lock: only power removal clears it
    always_ff @(posedge SYS_CLK_I) begin
        if (POR_I) begin
            lock_r <= 1'b0;
        end else if (wr_a && IO_WDATA_I[PA_LOCK]) begin
            lock_r <= 1'b1;
        end
    end

    // Address line twenty gate
    always_ff @(posedge SYS_CLK_I) begin
        if (RST_I || POR_I) begin
            gate20_r <= 1'b0;
        end else if (wr_a) begin
            gate20_r <= IO_WDATA_I[PA_GATE20];
        end
    end

    // Hot reset bit stays set while the processor reset runs
    always_ff @(posedge SYS_CLK_I) begin
        if (RST_I || POR_I) begin
            hot_rst_r <= 1'b0;
        end else if (wr_a) begin
            hot_rst_r <= IO_WDATA_I[PA_HOT_RST];
        end
    end

    // Starts are dropped while a sequence is running
    always_ff @(posedge SYS_CLK_I) begin
        if (RST_I || POR_I) begin
            alt_start_r <= 1'b0;
        end else begin
            alt_start_r <= hot_rise && !alt.busy;
        end
    end

    assign alt.start = alt_start_r;

    scp_alt_seq u_seq (
        .clk_i (SYS_CLK_I),
        .rst_i (RST_I || POR_I),
        .alt (alt.seq)
    );

    // Output flops
    always_ff @(posedge SYS_CLK_I) begin
        if (RST_I || POR_I) begin
            alt_rst_r <= 1'b0;
            rdata_r <= 8'h00;
        end else begin
            alt_rst_r <= alt.pulse;
            rdata_r <= rdata_nxt;
        end
    end

    assign IO_RDATA_O = rdata_r;
    assign NMI_O = nmi_r;
    assign ARB_HALT_O = nmi_r;
    assign TIMER_ZERO_IRQ_O = tmr_irq_r;
    assign SPEAKER_DATA_EN_O = spk_en_r;
    assign TIMER2_GATE_O = t2_gate_r;
    assign ADDRESS_LINE_TWENTY_GATE_O = gate20_r;
    assign PASSWORD_BLOCK_O = lock_r;
    assign CPU_ALT_RESET_O = alt_rst_r;
endmodule : scp_ports

// ==== test/scp_ports_monitor.sv ====
`timescale 1ns/1ps
module scp_ports_monitor
    import scp_pkg::*;
(
    input wire logic SYS_CLK_I, // Clock
    input wire logic RST_I, // System reset
    input wire logic POR_I, // Power-on reset
    input wire logic [15:0] IO_ADDR_I, // Address
    input wire logic IO_WR_I, // Write strobe
    input wire logic IO_RD_I, // Read strobe
    input wire logic [7:0] IO_WDATA_I, // Write data
    input wire logic [7:0] IO_RDATA_O, // Read data
    input wire logic CHAN_TIMEOUT_I, // Time-out
    input wire logic WATCHDOG_TO_I, // Watchdog
    input wire logic TIMER0_OUT_I, // Timer 0
    input wire logic TIMER2_OUT_I, // Timer 2
    input wire logic NMI_O, // NMI
    input wire logic ARB_HALT_O, // Arbitration halt
    input wire logic TIMER_ZERO_IRQ_O, // Timer latch
    input wire logic SPEAKER_DATA_EN_O, // Speaker
    input wire logic TIMER2_GATE_O, // Timer 2 gate
    input wire logic ADDRESS_LINE_TWENTY_GATE_O, // Line 20
    input wire logic PASSWORD_BLOCK_O, // Lock
    input wire logic CPU_ALT_RESET_O // Alternate reset
);
    default clocking cb @(posedge SYS_CLK_I); endclocking
    default disable iff (RST_I || POR_I);
    logic hot_r;
    logic [11:0] wait_r;
    // Decodes of the bus cycles the properties care about
    wire wr_a = IO_WR_I && IO_ADDR_I == PORT_A_ADDR;
    wire wr_b = IO_WR_I && IO_ADDR_I == PORT_B_ADDR;
    wire rd_a = IO_RD_I && IO_ADDR_I == PORT_A_ADDR;
    wire rd_b = IO_RD_I && IO_ADDR_I == PORT_B_ADDR;
    wire arb_clr = IO_WR_I && IO_ADDR_I == ARB_ADDR
        && !IO_WDATA_I[ARB_NMI_HOLD];
    wire req = wr_a && IO_WDATA_I[PA_HOT_RST] && !hot_r;
    // Shadow of the hot bit, so only a 0 to 1 write counts as request
    always_ff @(posedge SYS_CLK_I) begin
        if (RST_I || POR_I) hot_r <= 1'b0;
        else if (wr_a) hot_r <= IO_WDATA_I[PA_HOT_RST];
    end
    // Cycles since the request; saturates so it never wraps to 0
    always_ff @(posedge SYS_CLK_I) begin
        if (RST_I || POR_I) wait_r <= 12'hFFF;
        else if (req) wait_r <= 12'h000;
        else if (wait_r != 12'hFFF) wait_r <= wait_r + 12'h001;
    end
    sequence s_pulse_hi;
        CPU_ALT_RESET_O [*8] ##1 CPU_ALT_RESET_O [*2];
    endsequence
    a_nmi_unmasked: assert property (
        (WATCHDOG_TO_I || CHAN_TIMEOUT_I) |=> NMI_O && ARB_HALT_O)
        else $error("unmasked source gave no NMI");
    a_arb_tracks_nmi: assert property (
        ARB_HALT_O == NMI_O) else $error("halt differs from NMI");
    a_nmi_holds: assert property (
        NMI_O && !arb_clr |=> NMI_O) else $error("NMI dropped early");
    a_reset_clears: assert property (disable iff (1'b0)
        RST_I |=> !NMI_O && !ARB_HALT_O) else $error("NMI kept");
    a_irq_clear: assert property (
        wr_b && IO_WDATA_I[PB_IRQ_CLR] && $stable(TIMER0_OUT_I)
        |=> !TIMER_ZERO_IRQ_O) else $error("timer latch not cleared");
    a_port_b_read: assert property (
        rd_b |=> IO_RDATA_O[1:0] == {SPEAKER_DATA_EN_O, TIMER2_GATE_O}
        && IO_RDATA_O[PB_T2_OUT] == $past(TIMER2_OUT_I))
        else $error("port B read wrong");
    a_port_a_read: assert property (
        rd_a |=> IO_RDATA_O[7:5] == 3'h0 && !IO_RDATA_O[2]
        && IO_RDATA_O[PA_GATE20] == ADDRESS_LINE_TWENTY_GATE_O
        && IO_RDATA_O[PA_LOCK] == PASSWORD_BLOCK_O)
        else $error("port A read wrong");
    a_lock_sticky: assert property (
        PASSWORD_BLOCK_O |=> PASSWORD_BLOCK_O) else $error("lock lost");
    a_alt_pulse_width: assert property (
        $rose(CPU_ALT_RESET_O) |-> s_pulse_hi ##1 !CPU_ALT_RESET_O)
        else $error("alternate reset pulse width wrong");
    a_alt_not_early: assert property (
        $rose(CPU_ALT_RESET_O) |-> wait_r >= 12'h2A0)
        else $error("alternate reset too early");
endmodule : scp_ports_monitor
bind scp_ports scp_ports_monitor scp_ports_monitor_inst (
    .SYS_CLK_I(SYS_CLK_I), .RST_I(RST_I), .POR_I(POR_I),
    .IO_ADDR_I(IO_ADDR_I), .IO_WR_I(IO_WR_I), .IO_RD_I(IO_RD_I),
    .IO_WDATA_I(IO_WDATA_I), .IO_RDATA_O(IO_RDATA_O),
    .CHAN_TIMEOUT_I(CHAN_TIMEOUT_I), .WATCHDOG_TO_I(WATCHDOG_TO_I),
    .TIMER0_OUT_I(TIMER0_OUT_I), .TIMER2_OUT_I(TIMER2_OUT_I),
    .NMI_O(NMI_O), .ARB_HALT_O(ARB_HALT_O),
    .TIMER_ZERO_IRQ_O(TIMER_ZERO_IRQ_O),
    .SPEAKER_DATA_EN_O(SPEAKER_DATA_EN_O), .TIMER2_GATE_O(TIMER2_GATE_O),
    .ADDRESS_LINE_TWENTY_GATE_O(ADDRESS_LINE_TWENTY_GATE_O),
    .PASSWORD_BLOCK_O(PASSWORD_BLOCK_O), .CPU_ALT_RESET_O(CPU_ALT_RESET_O));

// ==== test/scp_cpu_model.sv ====
`timescale 1ns/1ps
module scp_cpu_model
    import scp_pkg::*;
(
    input wire logic clk_i, // System clock
    input wire logic [7:0] rdata_i, // Read data
    output logic [15:0] addr_o, // Address
    output logic wr_o, // Write strobe
    output logic rd_o, // Read strobe
    output logic [7:0] wdata_o // Write data
);
    // Idle bus at time zero
    initial begin
        {addr_o, wdata_o, wr_o, rd_o} = 26'h0;
    end
    // Released lines show the inverse, never the last value
    task automatic io_rd(input logic [15:0] a, output logic [7:0] d);
        @(posedge clk_i);
        addr_o <= a;
        rd_o <= 1'b1;
        @(posedge clk_i);
        rd_o <= 1'b0;
        addr_o <= ~a;
        #1;
        d = rdata_i;
    endtask : io_rd
    task automatic io_wr(input logic [15:0] a, input logic [7:0] d);
        logic [7:0] x;
        @(posedge clk_i);
        addr_o <= a;
        wdata_o <= d;
        wr_o <= 1'b1;
        @(posedge clk_i);
        wr_o <= 1'b0;
        addr_o <= ~a;
        wdata_o <= ~d;
        #1;
        if (a == CRAM_INDEX_ADDR) io_rd(16'h0071, x);
    endtask : io_wr
    // Interrupts masked first; the halt that follows is implied
    task automatic hot_reset();
        io_wr(CRAM_INDEX_ADDR, 8'h80);
        io_wr(PORT_A_ADDR, 8'h01);
    endtask : hot_reset
endmodule : scp_cpu_model

// ==== test/system_control_ports_nmi_tb.sv ====
`timescale 1ns/1ps
module system_control_ports_nmi_tb;
    import scp_pkg::*;
    typedef struct packed {
        logic [15:0] a; logic [7:0] w; logic [7:0] r; logic [2:0] o;
    } scp_row_s;
    // Write, read back; outputs are speaker, timer gate, line 20
    localparam scp_row_s ROWS [6] = '{
        '{PORT_B_ADDR, 8'h7F, 8'h0F, 3'h6}, '{PORT_B_ADDR, 8'h0D, 8'h0D, 3'h2},
        '{PORT_B_ADDR, 8'h0E, 8'h0E, 3'h4}, '{PORT_A_ADDR, 8'hE6, 8'h02, 3'h5},
        '{PORT_A_ADDR, 8'h00, 8'h00, 3'h4}, '{16'h0080, 8'h55, 8'h00, 3'h4}};
    logic clk, rst, por, par, chk, cto, wdg, t0, t2, rfr, v;
    logic [15:0] addr;
    logic wr, rd, nmi, arb, irq, spk, gate, ln20, lock, hot;
    logic [7:0] wdata, rdata, d;
    int n_errors = 0;
    int check_count = 0;
    int i, n;
    scp_ports scp_ports_inst (.SYS_CLK_I(clk), .RST_I(rst), .POR_I(por),
        .IO_ADDR_I(addr), .IO_WR_I(wr), .IO_RD_I(rd), .IO_WDATA_I(wdata),
        .IO_RDATA_O(rdata), .PARITY_ERR_I(par), .CHAN_CHECK_I(chk),
        .CHAN_TIMEOUT_I(cto), .WATCHDOG_TO_I(wdg), .TIMER0_OUT_I(t0),
        .TIMER2_OUT_I(t2), .REFRESH_REQ_I(rfr), .NMI_O(nmi),
        .ARB_HALT_O(arb), .TIMER_ZERO_IRQ_O(irq), .SPEAKER_DATA_EN_O(spk),
        .TIMER2_GATE_O(gate), .ADDRESS_LINE_TWENTY_GATE_O(ln20),
        .PASSWORD_BLOCK_O(lock), .CPU_ALT_RESET_O(hot));
    scp_cpu_model scp_cpu_model_inst (.clk_i(clk), .rdata_i(rdata),
        .addr_o(addr), .wr_o(wr), .rd_o(rd), .wdata_o(wdata));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic check(input logic [7:0] s, input logic [7:0] e);
        check_count++;
        if (s !== e) begin
            n_errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, s, e);
        end
    endtask : check
    task automatic end_of_test();
        if (n_errors == 0 && check_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : end_of_test
    task automatic wr_io(input logic [15:0] a, input logic [7:0] x);
        scp_cpu_model_inst.io_wr(a, x);
    endtask : wr_io
    task automatic rd_io(input logic [15:0] a);
        scp_cpu_model_inst.io_rd(a, d);
    endtask : rd_io
    task automatic do_reset(input logic p);
        @(posedge clk);
        rst <= 1'b1;
        por <= p;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        por <= 1'b0;
        #1;
    endtask : do_reset
    // One-cycle source pulse; timer 0 is left high so it rises once
    task automatic pulse(input int k);
        @(posedge clk);
        case (k)
            0: par <= 1'b1;
            1: chk <= 1'b1;
            2: wdg <= 1'b1;
            3: rfr <= 1'b1;
            4: cto <= 1'b1;
            default: t0 <= 1'b1;
        endcase
        @(posedge clk);
        {par, chk, wdg, rfr, cto} <= 5'h00;
        repeat (2) @(posedge clk);
        #1;
    endtask : pulse
    initial begin
        {rst, por, par, chk, cto, wdg, t0, t2, rfr} = 9'h180;
        do_reset(1'b1);
        rd_io(PORT_B_ADDR);
        check(d & 8'hEF, 8'h0C);
        for (i = 0; i < 6; i++) begin
            wr_io(ROWS[i].a, ROWS[i].w);
            rd_io(ROWS[i].a);
            check(d & 8'hEF, ROWS[i].r);
            check({5'h00, spk, gate, ln20}, {5'h00, ROWS[i].o});
        end
        // Power-on mask blocks parity, yet its flag still latches
        wr_io(PORT_B_ADDR, 8'h00);
        pulse(0);
        check({7'h00, nmi}, 8'h00);
        wr_io(CRAM_INDEX_ADDR, 8'h00);
        for (i = 0; i < 2; i++) begin
            pulse(i);
            check({6'h00, arb, nmi}, 8'h03);
            wr_io(ARB_ADDR, 8'h40);
            check({7'h00, nmi}, 8'h01);
            wr_io(ARB_ADDR, 8'h00);
            check({7'h00, nmi}, 8'h00);
        end
        rd_io(PORT_B_ADDR);
        check(d & 8'hC0, 8'hC0);
        // Unmaskable sources with the mask set again
        wr_io(CRAM_INDEX_ADDR, 8'h80);
        pulse(4);
        check({7'h00, nmi}, 8'h01);
        wr_io(ARB_ADDR, 8'h00);
        pulse(2);
        check({7'h00, nmi}, 8'h01);
        wr_io(PORT_A_ADDR, 8'h0A);
        wr_io(PORT_A_ADDR, 8'h00);
        rd_io(PORT_A_ADDR);
        check(d, 8'h18);
        check({7'h00, lock}, 8'h01);
        wr_io(PORT_A_ADDR, 8'h02);
        do_reset(1'b0);
        check({5'h00, nmi, ln20, lock}, 8'h01);
        do_reset(1'b1);
        check({7'h00, lock}, 8'h00);
        // Timer latch, timer 2 level and refresh toggle
        pulse(5);
        check({7'h00, irq}, 8'h01);
        wr_io(PORT_B_ADDR, 8'h8C);
        check({7'h00, irq}, 8'h00);
        @(posedge clk) t2 <= 1'b1;
        rd_io(PORT_B_ADDR);
        check(d & 8'h20, 8'h20);
        v = d[PB_REFRESH];
        pulse(3);
        rd_io(PORT_B_ADDR);
        check({7'h00, d[PB_REFRESH]}, {7'h00, ~v});
        // Hot reset: delay, width, bit held through the sequence
        scp_cpu_model_inst.hot_reset();
        for (n = 0; hot !== 1'b1 && n < 2000; n++) @(posedge clk) #1;
        check({7'h00, n >= 672 && n < 2000}, 8'h01);
        if (n == 2000) end_of_test();
        for (n = 0; hot === 1'b1 && n < 20; n++) @(posedge clk) #1;
        check(8'(n), 8'h0A);
        rd_io(PORT_A_ADDR);
        check(d & 8'h01, 8'h01);
        repeat (700) @(posedge clk);
        wr_io(PORT_A_ADDR, 8'h00);
        rd_io(PORT_A_ADDR);
        check(d & 8'h01, 8'h00);
        end_of_test();
    end
endmodule : system_control_ports_nmi_tb
